// >>> gpm_map.vh
// register offsets, field codes and reset values for the pin mux block
`ifndef GPM_MAP_VH
`define GPM_MAP_VH

// pin count and groups
`define GPM_NPINS       31
`define GPM_NGROUPS     7
`define GPM_GRP_STRIDE  8'h10
`define GPM_GRP0_BASE   5'd0
`define GPM_GRP0_WIDTH  5'd5
`define GPM_GRP1_BASE   5'd5
`define GPM_GRP1_WIDTH  5'd2
`define GPM_GRP2_BASE   5'd7
`define GPM_GRP2_WIDTH  5'd10
`define GPM_GRP4_BASE   5'd17
`define GPM_GRP4_WIDTH  5'd1
`define GPM_GRP5_BASE   5'd18
`define GPM_GRP5_WIDTH  5'd13

// per-group register offsets within a group block
`define GPM_OFS_FUNC_SEL  4'h0
`define GPM_OFS_DIR       4'h4
`define GPM_OFS_DATA_OUT  4'h8
`define GPM_OFS_DATA_IN   4'hc

// external interrupt registers
`define GPM_ADDR_IRQ_MODE   8'h80
`define GPM_ADDR_IRQ_FLAGS  8'h84
`define GPM_ADDR_IRQ_CLEAR  8'h88
`define GPM_ADDR_IRQ_ENABLE 8'h8c

// function select codes
`define GPM_FN_GPIO  2'h0
`define GPM_FN_ALT1  2'h1
`define GPM_FN_ALT2  2'h2
`define GPM_FN_ALT3  2'h3

// trigger modes
`define GPM_TRIG_LOW   2'h0
`define GPM_TRIG_HIGH  2'h1
`define GPM_TRIG_RISE  2'h2
`define GPM_TRIG_FALL  2'h3

// interrupt pins and their select code
`define GPM_IRQ_TWO_PIN    5'd0
`define GPM_IRQ_THREE_PIN  5'd17
`define GPM_IRQ_FN         2'h2

// reset values
`define GPM_RST_FUNC_SEL  62'h0
`define GPM_RST_DIR       31'h0
`define GPM_RST_DATA_OUT  31'h0
`define GPM_RST_IRQ_MODE  4'h0
`define GPM_RST_IRQ_EN    2'h0

`endif

// >>> gpm_sync.v
// two-flop synchroniser for a bus of independent levels
`timescale 1ns/1ns
module gpm_sync #(
	parameter WIDTH = 31
) (
	// clock and reset
	input  wire             pclk,
	input  wire             presetn,
	// levels
	input  wire [WIDTH-1:0] async_in,
	output reg  [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta     <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end
endmodule // gpm_sync

// >>> gpm_xirq.v
// trigger detector for one external interrupt input
`include "gpm_map.vh"
`timescale 1ns/1ns
module gpm_xirq (
	// clock and reset
	input  wire       pclk,
	input  wire       presetn,
	// synchronised pin level and control
	input  wire       level,
	input  wire       active,
	input  wire [1:0] mode,
	// trigger seen this cycle
	output reg        hit
);
	reg prev;

	// prev follows the pin even when inactive so selection adds no edge
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev <= 1'b0;
		end else begin
			prev <= level;
		end
	end

	always @* begin
		hit = 1'b0;
		if (active) begin
			case (mode)
				`GPM_TRIG_LOW:  hit = ~level;
				`GPM_TRIG_HIGH: hit = level;
				`GPM_TRIG_RISE: hit = level & ~prev;
				`GPM_TRIG_FALL: hit = ~level & prev;
				default:        hit = 1'b0;
			endcase
		end
	end
endmodule // gpm_xirq

// >>> gpm_top.v
// pin function multiplexer with general I/O and external interrupt sources
`include "gpm_map.vh"
`timescale 1ns/1ns
// Notes on behaviour
// - thirty-one pins are provided, each able to carry several functions.
// - every group's pin usage is set by software through registers.
// - a pin with no alternate function selected works as plain input/output.
// - both external interrupt inputs, on pin 0 and on the bus-wait pin, drive one shared request.
// - each external interrupt triggers on low level, high level, rising or falling edge.
// - a readable flag register tells software which external input raised the request.
// - pins form seven groups of 5, 2, 10, none, 1, 13 and none.
// - each pin chooses general I/O or one of up to three alternate functions.
module gpm_top (
	// apb slave
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output reg         pslverr,
	// pins
	input  wire [30:0] pin_in,
	output reg  [30:0] pin_out,
	output reg  [30:0] pin_oe,
	// alternate function units
	input  wire [30:0] alt1_out,
	input  wire [30:0] alt1_oe,
	input  wire [30:0] alt2_out,
	input  wire [30:0] alt2_oe,
	input  wire [30:0] alt3_out,
	input  wire [30:0] alt3_oe,
	output wire [30:0] pin_func_in,
	output reg  [61:0] pin_func_sel,
	// shared external interrupt request
	output wire        ext_irq_req
);
	// control state
	reg  [61:0] func_sel;
	reg  [30:0] dir;
	reg  [30:0] data_out;
	reg  [3:0]  irq_mode;
	reg  [1:0]  irq_enable;
	reg  [1:0]  ext_irq_source_flags;
	wire [30:0] pin_sync;
	wire        hit_two;
	wire        hit_three;
	wire        sel_two;
	wire        sel_three;

	// bus decode
	wire        wr_req;
	wire        rd_setup;
	wire [2:0]  grp;
	wire [3:0]  ofs;
	wire        grp_area;
	wire        grp_valid;
	reg  [31:0] rd_data;
	reg         rd_hit;
	reg  [61:0] next_func_sel;
	reg  [30:0] next_dir;
	reg  [30:0] next_data_out;
	integer     i;
	integer     j;
	integer     k;

	// group of a flat pin index
	function [2:0] pin_grp;
		input [4:0] p;
		begin
			if (p < `GPM_GRP1_BASE)
				pin_grp = 3'd0;
			else if (p < `GPM_GRP2_BASE)
				pin_grp = 3'd1;
			else if (p < `GPM_GRP4_BASE)
				pin_grp = 3'd2;
			else if (p < `GPM_GRP5_BASE)
				pin_grp = 3'd4;
			else
				pin_grp = 3'd5;
		end
	endfunction

	// position of a flat pin inside its group
	function [3:0] pin_pos;
		input [4:0] p;
		reg   [4:0] b;
		begin
			case (pin_grp(p))
				3'd0:    b = `GPM_GRP0_BASE;
				3'd1:    b = `GPM_GRP1_BASE;
				3'd2:    b = `GPM_GRP2_BASE;
				3'd4:    b = `GPM_GRP4_BASE;
				default: b = `GPM_GRP5_BASE;
			endcase
			pin_pos = p[3:0] - b[3:0];
		end
	endfunction

	// groups 3 and 6 have no pins
	function grp_exists;
		input [2:0] g;
		begin
			grp_exists = (g != 3'd3) && (g != 3'd6) && (g != 3'd7);
		end
	endfunction

	assign pready    = 1'b1;
	assign wr_req    = psel & penable & pwrite;
	assign rd_setup  = psel & ~penable;
	assign grp       = paddr[6:4];
	assign ofs       = paddr[3:0];
	assign grp_area  = (paddr[7] == 1'b0) && (grp < 3'd7);
	assign grp_valid = grp_area && grp_exists(grp);

	// writes into pin registers, scattered from group words to flat pins
	always @* begin
		next_func_sel = func_sel;
		next_dir      = dir;
		next_data_out = data_out;
		if (wr_req && grp_valid) begin
			for (i = 0; i < `GPM_NPINS; i = i + 1) begin
				if (pin_grp(i[4:0]) == grp) begin
					case (ofs)
						`GPM_OFS_FUNC_SEL: next_func_sel[2*i +: 2] = pwdata[2*pin_pos(i[4:0]) +: 2];
						`GPM_OFS_DIR:      next_dir[i] = pwdata[pin_pos(i[4:0])];
						`GPM_OFS_DATA_OUT: next_data_out[i] = pwdata[pin_pos(i[4:0])];
						default:           next_dir[i] = dir[i];
					endcase
				end
			end
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			func_sel   <= `GPM_RST_FUNC_SEL;
			dir        <= `GPM_RST_DIR;
			data_out   <= `GPM_RST_DATA_OUT;
			irq_mode   <= `GPM_RST_IRQ_MODE;
			irq_enable <= `GPM_RST_IRQ_EN;
		end else begin
			func_sel <= next_func_sel;
			dir      <= next_dir;
			data_out <= next_data_out;
			if (wr_req && paddr == `GPM_ADDR_IRQ_MODE)
				irq_mode <= pwdata[3:0];
			if (wr_req && paddr == `GPM_ADDR_IRQ_ENABLE)
				irq_enable <= pwdata[1:0];
		end
	end

	// read mux, gathered from flat pins into group words
	always @* begin
		rd_data = 32'h0;
		rd_hit  = 1'b0;
		if (grp_area && paddr[1:0] == 2'b00) begin
			// reserved groups answer with an error
			rd_hit = grp_exists(grp);
			if (grp_exists(grp)) begin
				for (j = 0; j < `GPM_NPINS; j = j + 1) begin
					if (pin_grp(j[4:0]) == grp) begin
						case (ofs)
							`GPM_OFS_FUNC_SEL: rd_data[2*pin_pos(j[4:0]) +: 2] = func_sel[2*j +: 2];
							`GPM_OFS_DIR:      rd_data[pin_pos(j[4:0])] = dir[j];
							`GPM_OFS_DATA_OUT: rd_data[pin_pos(j[4:0])] = data_out[j];
							`GPM_OFS_DATA_IN:  rd_data[pin_pos(j[4:0])] = pin_sync[j];
							default:           rd_data[pin_pos(j[4:0])] = 1'b0;
						endcase
					end
				end
			end
		end else begin
			case (paddr)
				`GPM_ADDR_IRQ_MODE: begin
					rd_hit  = 1'b1;
					rd_data = {28'h0, irq_mode};
				end
				`GPM_ADDR_IRQ_FLAGS: begin
					rd_hit  = 1'b1;
					rd_data = {30'h0, ext_irq_source_flags};
				end
				`GPM_ADDR_IRQ_CLEAR: begin
					rd_hit  = 1'b1;
					rd_data = 32'h0;
				end
				`GPM_ADDR_IRQ_ENABLE: begin
					rd_hit  = 1'b1;
					rd_data = {30'h0, irq_enable};
				end
				default: begin
					rd_hit  = 1'b0;
					rd_data = 32'h0;
				end
			endcase
		end
	end

	// answer prepared in the setup cycle so it comes from flops
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else if (rd_setup) begin
			prdata  <= pwrite ? 32'h0 : rd_data;
			pslverr <= ~rd_hit;
		end
	end

	// pin inputs cross into the bus clock
	gpm_sync #(
		.WIDTH(`GPM_NPINS)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.async_in(pin_in),
		.sync_out(pin_sync)
	);

	assign pin_func_in = pin_sync;

	// output mux per pin
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_out      <= 31'h0;
			pin_oe       <= 31'h0;
			pin_func_sel <= `GPM_RST_FUNC_SEL;
		end else begin
			pin_func_sel <= func_sel;
			for (k = 0; k < `GPM_NPINS; k = k + 1) begin
				case (func_sel[2*k +: 2])
					`GPM_FN_GPIO: begin
						pin_out[k] <= data_out[k];
						pin_oe[k]  <= dir[k];
					end
					`GPM_FN_ALT1: begin
						pin_out[k] <= alt1_out[k];
						pin_oe[k]  <= alt1_oe[k];
					end
					`GPM_FN_ALT2: begin
						pin_out[k] <= alt2_out[k];
						pin_oe[k]  <= alt2_oe[k] && k != `GPM_IRQ_TWO_PIN && k != `GPM_IRQ_THREE_PIN;
					end
					default: begin
						pin_out[k] <= alt3_out[k];
						pin_oe[k]  <= alt3_oe[k];
					end
				endcase
			end
		end
	end

	// external interrupt sources live only while their function is selected
	assign sel_two   = func_sel[2*`GPM_IRQ_TWO_PIN +: 2] == `GPM_IRQ_FN;
	assign sel_three = func_sel[2*`GPM_IRQ_THREE_PIN +: 2] == `GPM_IRQ_FN;

	gpm_xirq u_irq_two (
		.pclk   (pclk),
		.presetn(presetn),
		.level  (pin_sync[`GPM_IRQ_TWO_PIN]),
		.active (sel_two),
		.mode   (irq_mode[1:0]),
		.hit    (hit_two)
	);

	gpm_xirq u_irq_three (
		.pclk   (pclk),
		.presetn(presetn),
		.level  (pin_sync[`GPM_IRQ_THREE_PIN]),
		.active (sel_three),
		.mode   (irq_mode[3:2]),
		.hit    (hit_three)
	);

	// sticky flags, a new hit beats a clear in the same cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_irq_source_flags <= 2'h0;
		end else begin
			ext_irq_source_flags <= (ext_irq_source_flags
				& ~((wr_req && paddr == `GPM_ADDR_IRQ_CLEAR) ? pwdata[1:0] : 2'h0))
				| {hit_three, hit_two};
		end
	end

	assign ext_irq_req = |(ext_irq_source_flags & irq_enable);
endmodule // gpm_top

// >>> gpm_top_checker.sv
// port-level assertions for the pin mux block
`timescale 1ns/1ns
module gpm_top_checker (
	// apb
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	// pins and units
	input wire [30:0] pin_in,
	input wire [30:0] pin_out,
	input wire [30:0] pin_oe,
	input wire [30:0] alt1_out,
	input wire [30:0] alt1_oe,
	input wire [30:0] pin_func_in,
	input wire [61:0] pin_func_sel,
	input wire        ext_irq_req
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire acc = psel && penable;
	property sel_wr_p;
		acc && pwrite && paddr == 8'h00 |-> ##2 pin_func_sel[9:0] == $past(pwdata[9:0], 2);
	endproperty
	sel_write_a: assert property (sel_wr_p) else $error("select field not updated");
	ready_tied_a: assert property (pready) else $error("pready low");
	err_group_a: assert property (acc && (paddr[7:4] == 4'h3 || paddr[7:4] == 4'h6 || paddr[7:4] == 4'h7)
		|-> pslverr) else $error("reserved group accepted");
	flags_read_a: assert property (acc && paddr == 8'h84 |-> !pslverr && prdata[31:2] == 30'h0)
		else $error("flag register read wrong");
	err_zero_a: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0) else $error("error read not zero");
	rdata_hold_a: assert property (!($past(psel) && !$past(penable)) |-> $stable(prdata))
		else $error("read data moved");
	alt_route_a: assert property (pin_func_sel[3:2] == 2'h1 ##1 pin_func_sel[3:2] == 2'h1
		|-> pin_oe[1] == $past(alt1_oe[1]) && pin_out[1] == $past(alt1_out[1])) else $error("alt1 not routed");
	irq_oe_off_a: assert property (pin_func_sel[1:0] == 2'h2 ##1 pin_func_sel[1:0] == 2'h2 |-> !pin_oe[0])
		else $error("irq pin driven");
	sync_lat_a: assert property (1'b1 |-> ##2 (pin_func_in == $past(pin_in, 2))) else $error("input sync latency");
	irq_clear_a: assert property (acc && pwrite && paddr == 8'h88 && pwdata[1:0] == 2'h3
		&& pin_func_sel[1:0] != 2'h2 && pin_func_sel[35:34] != 2'h2
		&& $past(pin_func_sel[1:0]) != 2'h2 && $past(pin_func_sel[35:34]) != 2'h2
		|=> !ext_irq_req) else $error("request after clear");
	cover property (acc && pslverr);
	cover property (ext_irq_req);
	cover property (pin_func_sel[1:0] == 2'h2);
endmodule // gpm_top_checker
bind gpm_top gpm_top_checker chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.pready, .pslverr, .pin_in, .pin_out, .pin_oe, .alt1_out, .alt1_oe, .pin_func_in, .pin_func_sel, .ext_irq_req);

// >>> gpm_board_model.sv
// board devices and alternate function units around the pin mux
`timescale 1ns/1ns
module gpm_board_model (
	// pins
	input  wire [30:0] pin_out,
	input  wire [30:0] pin_oe,
	input  wire [30:0] ext_lvl,
	output wire [30:0] pin_in,
	// alternate units
	output wire [30:0] alt1_out,
	output wire [30:0] alt1_oe,
	output wire [30:0] alt2_out,
	output wire [30:0] alt2_oe,
	output wire [30:0] alt3_out,
	output wire [30:0] alt3_oe
);
	// driven pins read back, released pins follow the board
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
	// distinct fixed patterns so a wrong route shows
	assign alt1_out = 31'h2aaaaaaa;
	assign alt1_oe = 31'h7fffffff;
	assign alt2_out = 31'h15555555;
	assign alt2_oe = 31'h0f0f0f0f;
	assign alt3_out = 31'h7f00ff00;
	assign alt3_oe = 31'h70f0f0f0;
endmodule // gpm_board_model

// >>> gpio_pin_mux_ext_irq_tb.sv
// self-checking bench for the pin mux block
`timescale 1ns/1ns
module gpio_pin_mux_ext_irq_tb;
	reg         pclk;
	reg         presetn;
	reg         psel;
	reg         penable;
	reg         pwrite;
	reg  [7:0]  paddr;
	reg  [31:0] pwdata;
	reg  [30:0] ext_lvl;
	reg  [31:0] rd;
	reg         er;
	reg         t;
	reg  [30:0] ao, ae;
	reg  [29:0] wid = {5'd13, 5'd1, 5'd0, 5'd10, 5'd2, 5'd5};
	reg  [39:0] bad_adr = 40'h30_60_70_90_01;
	wire [31:0] prdata;
	wire        pready;
	wire        pslverr;
	wire        ext_irq_req;
	wire [30:0] pin_in, pin_out, pin_oe, pin_func_in;
	wire [30:0] a1o, a1e, a2o, a2e, a3o, a3e;
	wire [61:0] pin_func_sel;
	integer     bad_count;
	integer     samples_checked;
	integer     i, m;
	gpm_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .alt1_out(a1o), .alt1_oe(a1e),
		.alt2_out(a2o), .alt2_oe(a2e), .alt3_out(a3o), .alt3_oe(a3e), .pin_func_in(pin_func_in),
		.pin_func_sel(pin_func_sel), .ext_irq_req(ext_irq_req));
	gpm_board_model bm_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_in(pin_in),
		.alt1_out(a1o), .alt1_oe(a1e), .alt2_out(a2o), .alt2_oe(a2e), .alt3_out(a3o), .alt3_oe(a3e));
	task summarize;
		begin
			$display("checks %0d mismatches %0d", samples_checked, bad_count);
			if (bad_count == 0 && samples_checked > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	task chk(input [63:0] nm, input [31:0] got, input [31:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("mismatch %0s expected %h seen %h", nm, exp, got);
			end
		end
	endtask
	task apb(input w, input [7:0] a, input [31:0] d);
		integer n;
		begin
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			n = 0;
			do begin
				@(posedge pclk);
				n = n + 1;
			end while (pready !== 1'b1 && n < 20);
			if (pready !== 1'b1) begin
				bad_count = bad_count + 1;
				summarize;
			end
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
		end
	endtask
	task rchk(input [7:0] a, input [31:0] e, input ee);
		begin
			apb(1'b0, a, 32'h0);
			chk("rdata", rd, e);
			chk("slverr", {31'h0, er}, {31'h0, ee});
		end
	endtask
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		ext_lvl = 31'h0;
		bad_count = 0;
		samples_checked = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (i = 0; i < 6; i = i + 1)
			if (i != 3) begin
				for (m = 0; m < 3; m = m + 1)
					rchk(8'(i * 16 + m * 4), 32'h0, 1'b0);
				apb(1'b1, 8'(i * 16 + 4), 32'hffffffff);
				rchk(8'(i * 16 + 4), (32'h1 << wid[i*5+:5]) - 32'h1, 1'b0);
				apb(1'b1, 8'(i * 16 + 4), 32'h0);
			end
		rchk(8'h80, 32'h0, 1'b0);
		rchk(8'h8c, 32'h0, 1'b0);
		for (i = 0; i < 5; i = i + 1)
			rchk(bad_adr[i*8+:8], 32'h0, 1'b1);
		apb(1'b1, 8'h60, 32'hffffffff);
		chk("slverr", {31'h0, er}, 32'h1);
		apb(1'b1, 8'h24, 32'h3ff);
		apb(1'b1, 8'h28, 32'h155);
		repeat (3) @(posedge pclk);
		chk("oe", {22'h0, pin_oe[16:7]}, 32'h3ff);
		chk("out", {22'h0, pin_out[16:7]}, 32'h155);
		rchk(8'h2c, 32'h155, 1'b0);
		apb(1'b1, 8'h24, 32'h0);
		ext_lvl <= {14'h0, 10'h2aa, 7'h0};
		repeat (4) @(posedge pclk);
		rchk(8'h2c, 32'h2aa, 1'b0);
		chk("fin", {22'h0, pin_func_in[16:7]}, 32'h2aa);
		for (m = 1; m < 4; m = m + 1) begin
			ao = (m == 1) ? a1o : (m == 2) ? a2o : a3o;
			ae = (m == 1) ? a1e : (m == 2) ? a2e : a3e;
			apb(1'b1, 8'h00, m * 32'h155);
			repeat (3) @(posedge pclk);
			chk("sel", {22'h0, pin_func_sel[9:0]}, m * 32'h155);
			chk("out", {28'h0, pin_out[4:1]}, {28'h0, ao[4:1]});
			chk("oe", {27'h0, pin_oe[4:0]}, {27'h0, ae[4:1], (m == 2) ? 1'b0 : ae[0]});
		end
		apb(1'b1, 8'h8c, 32'h1);
		for (m = 0; m < 4; m = m + 1) begin
			t = m[1] ^ m[0];
			apb(1'b1, 8'h00, 32'h0);
			apb(1'b1, 8'h80, m);
			ext_lvl <= {30'h0, ~t};
			repeat (4) @(posedge pclk);
			apb(1'b1, 8'h88, 32'h3);
			apb(1'b1, 8'h00, 32'h2);
			rchk(8'h84, 32'h0, 1'b0);
			ext_lvl <= {30'h0, t};
			repeat (4) @(posedge pclk);
			chk("irq", {31'h0, ext_irq_req}, 32'h1);
			ext_lvl <= {30'h0, ~t};
			repeat (4) @(posedge pclk);
			rchk(8'h84, 32'h1, 1'b0);
			apb(1'b1, 8'h88, 32'h1);
			rchk(8'h84, 32'h0, 1'b0);
			chk("irq", {31'h0, ext_irq_req}, 32'h0);
		end
		apb(1'b1, 8'h8c, 32'h0);
		apb(1'b1, 8'h80, 32'h4);
		apb(1'b1, 8'h40, 32'h2);
		apb(1'b1, 8'h88, 32'h3);
		ext_lvl <= 31'h20001;
		repeat (4) @(posedge pclk);
		rchk(8'h84, 32'h2, 1'b0);
		chk("irq", {31'h0, ext_irq_req}, 32'h0);
		apb(1'b1, 8'h8c, 32'h2);
		chk("irq", {31'h0, ext_irq_req}, 32'h1);
		ext_lvl <= 31'h1;
		repeat (4) @(posedge pclk);
		apb(1'b1, 8'h88, 32'h2);
		chk("irq", {31'h0, ext_irq_req}, 32'h0);
		summarize;
	end
endmodule // gpio_pin_mux_ext_irq_tb
